// file: logic/spi_register_client.sv
// Serial register access client: frames, opcodes, address, read and write data.
// Assumes the link clock, select and data lines come from the host asynchronously and are
// oversampled by i_clk; the register side answers reads within a few system cycles.
//
// What this block does
// - Select low opens a frame, high ignores all.
// - Dual read: opcode x1, address and dummy x2.
// - Dual read output starts on next falling edge.
// - Quad read: opcode x1, address and dummy x4.
// - Quad read output starts on next falling edge.
// - Release data lines when select rises.
// - Dual/quad commands rejected in quad-wide mode.
// - Two address bytes form a byte address.
// - Bits 15:14 pick increment, decrement or hold.
// - Further words follow while select stays low.
// - Plain write outside quad-wide mode takes everything one bit per clock.
// - Quad-wide write takes everything four bits.
// - Data arrives low byte first, high bits first.
// - Only complete 32-bit words reach a register.
// - Dual data write: header x1, data x2.
// - Quad data write: header x1, data x4.
`timescale 1ns/1ps
module spi_register_client (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_quad_wide_protocol,
    input wire logic i_sclk,
    input wire logic i_client_select_n,
    input wire logic [3:0] i_serial_io_lines,
    output logic [3:0] o_serial_io_lines,
    output logic [3:0] o_serial_io_lines_oe_n,
    output logic o_rd_valid,
    output logic [spi_client_pkg::ADDR_W-1:0] o_rd_addr,
    input wire logic i_rd_ack,
    input wire logic [spi_client_pkg::WORD_W-1:0] i_rd_data,
    output logic o_wr_valid,
    output logic [spi_client_pkg::ADDR_W-1:0] o_wr_addr,
    output logic [spi_client_pkg::WORD_W-1:0] o_wr_data,
    input wire logic i_wr_ready,
    output logic o_write_overrun
);
    import spi_client_pkg::*;

    // Swap byte order: the link carries the low byte first
    function automatic logic [WORD_W-1:0] byte_swap(input logic [WORD_W-1:0] w);
        byte_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction
    // Shift the sampled lanes into the receive register
    function automatic logic [WORD_W-1:0] take_bits(input logic [WORD_W-1:0] sr,
                                                    input logic [3:0] serial_io_lines,
                                                    input logic [2:0] lanes);
        case (lanes)
            LANES_2: take_bits = {sr[WORD_W-3:0], serial_io_lines[1:0]};
            LANES_4: take_bits = {sr[WORD_W-5:0], serial_io_lines[3:0]};
            default: take_bits = {sr[WORD_W-2:0], serial_io_lines[0]};
        endcase
    endfunction
    // Next word address for the selected address mode
    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                    input logic [1:0] mode);
        case (mode)
            MODE_INC: step_addr = a + WORD_STEP;
            MODE_DEC: step_addr = a - WORD_STEP;
            default: step_addr = a;
        endcase
    endfunction
    // Synchronisers; the first stages feed only the second stages
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;         // Delayed copy for edge finding
    logic cs_m;
    logic cs_s;
    logic [3:0] sio_m;
    logic [3:0] sio_s;
    // Frame state
    state_t state;
    logic [5:0] bit_cnt;        // Bits taken in the current phase
    logic [WORD_W-1:0] rx_sr;   // Receive shift register
    logic frame_quad;           // Mode latched at frame start
    logic [2:0] addr_w;         // Lanes for address and dummy
    logic [2:0] data_w;         // Lanes for data
    logic [5:0] dummy_len;      // Dummy phase length in bits
    logic is_read;              // Current command reads
    // Address
    logic [1:0] addr_mode;
    logic [ADDR_W-1:0] word_addr;
    // Read path
    logic [WORD_W-1:0] rd_buf;  // Prefetched word
    logic [WORD_W-1:0] tx_sr;   // Outgoing bits, top first
    logic [5:0] tx_cnt;         // Bits sent of current word
    // Write path, one word held for the FIFO
    logic pend_valid;
    logic [ADDR_W-1:0] pend_addr;
    logic [WORD_W-1:0] pend_data;
    logic fifo_in_ready;
    // Decoded events
    logic rise;
    logic fall;
    logic active;
    logic [2:0] phase_w;
    logic [5:0] phase_len;
    logic last;
    logic [WORD_W-1:0] rx_next;
    logic addr_done;
    logic word_done;
    logic consume;
    logic [WORD_W-1:0] tx_src;

    // Two-flop synchronisers for all link inputs
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sclk_m <= 1'b0;
            sclk_s <= 1'b0;
            sclk_d <= 1'b0;
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            sio_m <= LINES_IDLE;
            sio_s <= LINES_IDLE;
        end else begin
            sclk_m <= i_sclk;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            cs_m <= i_client_select_n;
            cs_s <= cs_m;
            sio_m <= i_serial_io_lines;
            sio_s <= sio_m;
        end
    end

    // Edges of the link clock; data lines share its delay so stay aligned
    assign rise = sclk_s && !sclk_d;
    assign fall = !sclk_s && sclk_d;
    assign active = !cs_s;
    // Lane count and length of the phase in progress
    always_comb begin
        phase_w = LANES_1;
        phase_len = WORD_BITS;
        case (state)
            S_OPCODE: begin
                phase_w = frame_quad ? LANES_4 : LANES_1;
                phase_len = OPCODE_BITS;
            end
            S_ADDR: begin
                phase_w = addr_w;
                phase_len = ADDR_BITS;
            end
            S_DUMMY: begin
                phase_w = addr_w;
                phase_len = dummy_len;
            end
            S_WDATA: phase_w = data_w;
            default: phase_w = LANES_1;
        endcase
    end
    assign rx_next = take_bits(rx_sr, sio_s, phase_w);
    assign last = ((bit_cnt + {3'h0, phase_w}) == phase_len);
    assign addr_done = active && rise && (state == S_ADDR) && last;
    assign word_done = active && rise && (state == S_WDATA) && last;
    assign consume = active && fall && (state == S_RDATA) && (tx_cnt == '0);

    // Frame sequencing; select high drops any partial word
    always_ff @(posedge i_clk) begin
        if (i_srst || !active) begin
            state <= S_IDLE;
            bit_cnt <= '0;
            rx_sr <= '0;
        end else if (state == S_IDLE) begin
            state <= S_OPCODE;
            bit_cnt <= '0;
        end else if (rise && state != S_RDATA && state != S_IGNORE) begin
            rx_sr <= rx_next;
            bit_cnt <= last ? 6'h00 : bit_cnt + {3'h0, phase_w};
            if (last) begin
                case (state)
                    S_OPCODE: begin
                        // Only the plain write exists in quad-wide mode
                        if (rx_next[7:0] == OP_WRITE) begin
                            state <= S_ADDR;
                        end else if (frame_quad) begin
                            state <= S_IGNORE;
                        end else if (rx_next[7:0] == OP_DUAL_DATA_WRITE ||
                                     rx_next[7:0] == OP_QUAD_DATA_WRITE ||
                                     rx_next[7:0] == OP_DUAL_IO_READ ||
                                     rx_next[7:0] == OP_QUAD_IO_READ) begin
                            state <= S_ADDR;
                        end else begin
                            state <= S_IGNORE;
                        end
                    end
                    S_ADDR: state <= is_read ? S_DUMMY : S_WDATA;
                    S_DUMMY: state <= S_RDATA;
                    S_WDATA: state <= S_WDATA;
                    default: state <= S_IGNORE;
                endcase
            end
        end
    end

    // Command attributes, decoded once the opcode is complete
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            frame_quad <= 1'b0;
            addr_w <= LANES_1;
            data_w <= LANES_1;
            dummy_len <= DUAL_DUMMY_BITS;
            is_read <= 1'b0;
        end else if (state == S_IDLE) begin
            frame_quad <= i_quad_wide_protocol;  // Mode may not change mid-frame
        end else if (active && rise && state == S_OPCODE && last) begin
            case (rx_next[7:0])
                OP_DUAL_IO_READ: begin
                    addr_w <= LANES_2;
                    data_w <= LANES_2;
                    dummy_len <= DUAL_DUMMY_BITS;
                    is_read <= 1'b1;
                end
                OP_QUAD_IO_READ: begin
                    addr_w <= LANES_4;
                    data_w <= LANES_4;
                    dummy_len <= QUAD_DUMMY_BITS;
                    is_read <= 1'b1;
                end
                OP_DUAL_DATA_WRITE: begin
                    addr_w <= LANES_1;
                    data_w <= LANES_2;
                    is_read <= 1'b0;
                end
                OP_QUAD_DATA_WRITE: begin
                    addr_w <= LANES_1;
                    data_w <= LANES_4;
                    is_read <= 1'b0;
                end
                default: begin
                    addr_w <= frame_quad ? LANES_4 : LANES_1;
                    data_w <= frame_quad ? LANES_4 : LANES_1;
                    is_read <= 1'b0;
                end
            endcase
        end
    end

    // Word address: loaded from the header, stepped after each word
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            addr_mode <= 2'h0;
            word_addr <= '0;
        end else if (addr_done) begin
            addr_mode <= rx_next[15:14];
            word_addr <= rx_next[ADDR_W-1:0];
        end else if (word_done || consume) begin
            word_addr <= step_addr(word_addr, addr_mode);
        end
    end

    // Read requests: one after the header, then one per word taken
    // Dummy clocks give the register side time before the first bit leaves
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rd_valid <= 1'b0;
            rd_buf <= '0;
        end else begin
            if ((addr_done && is_read) || consume) begin
                o_rd_valid <= 1'b1;
            end else if (i_rd_ack) begin
                o_rd_valid <= 1'b0;
            end
            if (i_rd_ack) begin
                rd_buf <= i_rd_data;
            end
        end
    end

    assign o_rd_addr = word_addr;
    // Outgoing word: start a new word from the buffer, otherwise keep shifting
    assign tx_src = (tx_cnt == '0) ? byte_swap(rd_buf) : tx_sr;

    // Output lanes change on falling link edges and are released on deselect
    always_ff @(posedge i_clk) begin
        if (i_srst || !active) begin
            o_serial_io_lines_oe_n <= LINES_RELEASED;
            o_serial_io_lines <= LINES_IDLE;
            tx_sr <= '0;
            tx_cnt <= '0;
        end else if (fall && state == S_RDATA) begin
            if (data_w == LANES_4) begin
                o_serial_io_lines <= tx_src[WORD_W-1:WORD_W-4];
                o_serial_io_lines_oe_n <= 4'h0;
                tx_sr <= {tx_src[WORD_W-5:0], 4'h0};
            end else begin
                o_serial_io_lines <= {2'h0, tx_src[WORD_W-1:WORD_W-2]};
                o_serial_io_lines_oe_n <= 4'hc;
                tx_sr <= {tx_src[WORD_W-3:0], 2'h0};
            end
            tx_cnt <= ((tx_cnt + {3'h0, data_w}) == WORD_BITS) ? 6'h00
                      : tx_cnt + {3'h0, data_w};
        end
    end

    // Completed write word waits here until the FIFO accepts it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pend_valid <= 1'b0;
            pend_addr <= '0;
            pend_data <= '0;
            o_write_overrun <= 1'b0;
        end else begin
            o_write_overrun <= word_done && pend_valid && !fifo_in_ready;
            if (word_done && !(pend_valid && !fifo_in_ready)) begin
                pend_valid <= 1'b1;
                pend_addr <= word_addr;
                pend_data <= byte_swap(rx_next);
            end else if (fifo_in_ready) begin
                pend_valid <= 1'b0;
            end
        end
    end

    // Write FIFO toward the register side
    word_fifo #(
        .WIDTH(ADDR_W + WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_write_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_in_valid(pend_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data({pend_addr, pend_data}),
        .o_out_valid(o_wr_valid),
        .i_out_ready(i_wr_ready),
        .o_out_data({o_wr_addr, o_wr_data})
    );

    // Checks on the design's own behaviour
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_last_dummy;
        active && rise && (state == S_DUMMY) && last;
    endsequence
    sequence s_bad_opcode_quad;
        active && rise && (state == S_OPCODE) && last && frame_quad &&
            (rx_next[7:0] != OP_WRITE);
    endsequence
    a_deselect_idle: assert property (!active |=> state == S_IDLE)
        else $error("frame state not idle after deselect");
    a_lines_released: assert property (!active |=> o_serial_io_lines_oe_n == 4'hf)
        else $error("data lines still driven after deselect");
    a_quad_reject: assert property (s_bad_opcode_quad |=> state == S_IGNORE)
        else $error("dual or quad command accepted in quad-wide mode");
    a_read_entry: assert property (s_last_dummy |=>
        state == S_RDATA && o_serial_io_lines_oe_n == 4'hf)
        else $error("read data phase not entered after last dummy");
    a_first_drive: assert property (
        (state == S_RDATA) && active && fall && (o_serial_io_lines_oe_n == 4'hf)
        |=> o_serial_io_lines_oe_n != 4'hf)
        else $error("lines not driven on first falling edge of read");
    a_addr_increment: assert property (word_done && addr_mode == MODE_INC
        |=> word_addr == $past(word_addr) + WORD_STEP)
        else $error("word address did not increment");
    a_addr_decrement: assert property (word_done && addr_mode == MODE_DEC
        |=> word_addr == $past(word_addr) - WORD_STEP)
        else $error("word address did not decrement");
    a_whole_word_only: assert property ($rose(pend_valid) |-> $past(word_done))
        else $error("write word queued without 32 bits");
    a_read_request: assert property (addr_done && is_read |=> o_rd_valid)
        else $error("no register read after read header");
endmodule

// file: logic/spi_client_pkg.sv
// Constants, command codes and state type shared by the serial client and its bench.
// Assumes a single system clock at 100 MHz and a synchronous active-high reset.
package spi_client_pkg;

    // Instruction codes, always sent most significant bit first
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_DUAL_DATA_WRITE = 8'h32;
    localparam logic [7:0] OP_QUAD_DATA_WRITE = 8'h62;
    localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
    localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;

    // Widths of the register side
    localparam int ADDR_W = 14;
    localparam int WORD_W = 32;
    localparam int FIFO_DEPTH = 8;

    // Phase lengths in link bits
    localparam logic [5:0] OPCODE_BITS = 6'h08;
    localparam logic [5:0] ADDR_BITS = 6'h10;
    localparam logic [5:0] DUAL_DUMMY_BITS = 6'h10;
    localparam logic [5:0] QUAD_DUMMY_BITS = 6'h20;
    localparam logic [5:0] WORD_BITS = 6'h20;

    // Address mode field held in address bits 15:14
    localparam logic [1:0] MODE_INC = 2'h1;
    localparam logic [1:0] MODE_DEC = 2'h2;
    localparam logic [ADDR_W-1:0] WORD_STEP = 14'h0004;

    // Lanes used per link clock
    localparam logic [2:0] LANES_1 = 3'h1;
    localparam logic [2:0] LANES_2 = 3'h2;
    localparam logic [2:0] LANES_4 = 3'h4;

    // Values after reset
    localparam logic [3:0] LINES_RELEASED = 4'hf;
    localparam logic [3:0] LINES_IDLE = 4'h0;

    // Frame sequencing states
    typedef enum logic [2:0] {
        S_IDLE,
        S_OPCODE,
        S_ADDR,
        S_DUMMY,
        S_WDATA,
        S_RDATA,
        S_IGNORE
    } state_t;

endpackage

// file: logic/word_fifo.sv
// Flip-flop FIFO with valid/ready on both sides, width and depth as parameters.
// Assumes both sides run on i_clk; out data is read straight from the storage flops.
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 46,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W-1:0] LAST_IDX = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];  // Storage words
    logic [PTR_W-1:0] wr_ptr;       // Next slot to fill
    logic [PTR_W-1:0] rd_ptr;       // Oldest slot
    logic [PTR_W:0] count;          // Words held
    logic push;
    logic pop;

    // Honest flags: full stalls the source, empty hides stale data
    assign o_in_ready = (count != FULL_COUNT);
    assign o_out_valid = (count != '0);
    assign o_out_data = mem[rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Storage write; no reset needed since empty masks it
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    // Occupancy
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end

endmodule

// file: bench/serial_host_model.sv
// Serial host model: select, link clock and data lanes, 125 ns link period.
// Assumes the bench resolves the shared lines and feeds the wire level back on i_sio.
`timescale 1ns/1ps
module serial_host_model (
    input wire logic [3:0] i_sio,
    output logic o_sclk,
    output logic o_select_n,
    output logic [3:0] o_sio
);
    // Link clock stands low outside frames, select idle high
    initial begin
        o_sclk = 1'b0;
        o_select_n = 1'b1;
        o_sio = 4'h0;
    end
    // One link clock: lines change while low, wire sampled at the rise
    task automatic tick(input logic [3:0] drv, output logic [3:0] seen);
        o_sio = drv;
        #62.5 o_sclk = 1'b1;
        seen = i_sio;
        #62.5 o_sclk = 1'b0;
    endtask
    // Margins leave room for the client's select synchroniser
    task automatic open_frame();
        #100 o_select_n = 1'b0;
        #100;
    endtask
    task automatic close_frame();
        #62.5 o_select_n = 1'b1;
        #100;
    endtask
    // One byte, top bits first; unused lanes toggle so stale levels never match
    task automatic send_byte(input logic [7:0] b, input int lanes);
        logic [3:0] seen;
        for (int i = 0; i < 8 / lanes; i++) begin
            case (lanes)
                1: tick({~o_sio[3:1], b[7]}, seen);
                2: tick({~o_sio[3:2], b[7:6]}, seen);
                default: tick(b[7:4], seen);
            endcase
            b = b << lanes;
        end
    endtask
    // A word goes out low byte first
    task automatic send_word(input logic [31:0] w, input int lanes);
        for (int k = 0; k < 4; k++) begin
            send_byte(w[8*k +: 8], lanes);
        end
    endtask
    // Lines released by the host carry an inverting pattern while reading
    task automatic recv_word(input int lanes, output logic [31:0] w);
        logic [3:0] seen;
        logic [7:0] b;
        b = 8'h00;
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 8 / lanes; i++) begin
                tick(~o_sio, seen);
                b = (lanes == 2) ? {b[5:0], seen[1:0]} : {b[3:0], seen};
            end
            w[8*k +: 8] = b;
        end
    endtask
endmodule

// file: bench/test_spi_register_client.sv
// Self-checking bench for the serial register client.
// Assumes the host model drives the link; this bench plays the register side.
`timescale 1ns/1ps
module test_spi_register_client;
    import spi_client_pkg::*;
    logic clk, srst, quad_wide, rd_ack, wr_ready, rd_valid, wr_valid, overrun;
    logic [WORD_W-1:0] rd_data, wr_data;
    logic [ADDR_W-1:0] rd_addr, wr_addr;
    logic sclk, select_n;
    logic [3:0] host_sio, dev_sio, dev_oe_n, serial_io_lines;
    logic [45:0] wq[$];
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int overruns = 0;
    // Wire level: the client wins where its enable is low
    assign serial_io_lines = (dev_oe_n & host_sio) | (~dev_oe_n & dev_sio);
    spi_register_client dut (.i_clk(clk), .i_srst(srst), .i_quad_wide_protocol(quad_wide),
        .i_sclk(sclk), .i_client_select_n(select_n), .i_serial_io_lines(serial_io_lines),
        .o_serial_io_lines(dev_sio), .o_serial_io_lines_oe_n(dev_oe_n),
        .o_rd_valid(rd_valid), .o_rd_addr(rd_addr), .i_rd_ack(rd_ack), .i_rd_data(rd_data),
        .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
        .i_wr_ready(wr_ready), .o_write_overrun(overrun));
    serial_host_model host (.i_sio(serial_io_lines), .o_sclk(sclk), .o_select_n(select_n),
        .o_sio(host_sio));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Register contents follow from the address, so any wrong fetch shows
    function automatic logic [31:0] reg_word(input logic [13:0] a);
        return {a, 4'ha, a};
    endfunction
    // Register side: ack one cycle after a request, log writes, cut hangs
    always @(posedge clk) begin
        rd_ack <= !srst && rd_valid && !rd_ack;
        rd_data <= reg_word(rd_addr);
        if (wr_valid && wr_ready) wq.push_back({wr_addr, wr_data});
        if (overrun === 1'b1) overruns++;
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic expect_write(input logic [13:0] a, input logic [31:0] d);
        logic [45:0] e;
        if (wq.size() == 0) e = '1;
        else e = wq.pop_front();
        check("write addr", {18'h0, a}, {18'h0, e[45:32]});
        check("write data", d, e[31:0]);
    endtask
    task automatic wait_writes(input int n);
        for (int i = 0; i < 300 && wq.size() < n; i++) @(posedge clk);
    endtask
    task automatic header(input logic [7:0] op, input int ol, input int al, input logic [15:0] a);
        host.open_frame();
        host.send_byte(op, ol);
        host.send_byte(a[15:8], al);
        host.send_byte(a[7:0], al);
    endtask
    // Two-word read with dummy phase; address steps as the mode field says
    task automatic read_frame(input logic [7:0] op, input int ln, input logic [15:0] a,
                              input logic [3:0] oe);
        logic [31:0] w;
        logic [13:0] e;
        header(op, 1, ln, a);
        for (int k = 0; k < ln; k++) host.send_byte(8'h00, ln);
        e = a[13:0];
        for (int k = 0; k < 2; k++) begin
            host.recv_word(ln, w);
            check("read data", reg_word(e), w);
            check("read enable", {28'h0, oe}, {28'h0, dev_oe_n});
            e = (a[15:14] == MODE_INC) ? e + WORD_STEP : e - WORD_STEP;
        end
        host.close_frame();
        check("release", 32'hf, {28'h0, dev_oe_n});
    endtask
    task automatic test_single_write();
        header(OP_WRITE, 1, 1, {MODE_INC, 14'h0100});
        host.send_word(32'ha1b2c3d4, 1);
        host.send_word(32'h5e6f7081, 1);
        host.close_frame();
        wait_writes(2);
        expect_write(14'h0100, 32'ha1b2c3d4);
        expect_write(14'h0104, 32'h5e6f7081);
        $display("test single_write done");
    endtask
    task automatic test_dual_write();
        header(OP_DUAL_DATA_WRITE, 1, 1, {MODE_DEC, 14'h0208});
        host.send_word(32'h0f1e2d3c, 2);
        host.send_word(32'h4b5a6978, 2);
        host.close_frame();
        wait_writes(2);
        expect_write(14'h0208, 32'h0f1e2d3c);
        expect_write(14'h0204, 32'h4b5a6978);
        $display("test dual_write done");
    endtask
    // Hold mode with both mode bits set, then a word cut short by select
    task automatic test_quad_partial();
        header(OP_QUAD_DATA_WRITE, 1, 1, {2'h3, 14'h3ffc});
        host.send_word(32'h89abcdef, 4);
        host.send_word(32'h01234567, 4);
        for (int k = 0; k < 3; k++) host.send_byte(8'ha5, 4);
        host.close_frame();
        wait_writes(3);
        expect_write(14'h3ffc, 32'h89abcdef);
        expect_write(14'h3ffc, 32'h01234567);
        check("write count", 32'h0, wq.size());
        $display("test quad_partial done");
    endtask
    task automatic test_quad_wide();
        logic [7:0] ops [4] = '{OP_DUAL_DATA_WRITE, OP_QUAD_DATA_WRITE,
                                OP_DUAL_IO_READ, OP_QUAD_IO_READ};
        @(posedge clk) quad_wide <= 1'b1;
        header(OP_WRITE, 4, 4, {2'h0, 14'h0010});
        host.send_word(32'h13579bdf, 4);
        host.close_frame();
        wait_writes(1);
        expect_write(14'h0010, 32'h13579bdf);
        foreach (ops[i]) begin
            header(ops[i], 4, 4, {MODE_INC, 14'h0020});
            // Long enough that a wrongly accepted command reaches its data phase
            for (int k = 0; k < 4; k++) host.send_word(32'hffff0000, 4);
            check("rejected enable", 32'hf, {28'h0, dev_oe_n});
            host.close_frame();
        end
        wait_writes(1);
        check("write count", 32'h0, wq.size());
        @(posedge clk) quad_wide <= 1'b0;
        $display("test quad_wide done");
    endtask
    task automatic test_reads();
        read_frame(OP_DUAL_IO_READ, 2, {MODE_INC, 14'h0040}, 4'hc);
        read_frame(OP_QUAD_IO_READ, 4, {MODE_DEC, 14'h0080}, 4'h0);
        $display("test reads done");
    endtask
    // Register side stalls: eight queued, one held, the tenth word lost
    task automatic test_fifo_full();
        @(posedge clk) wr_ready <= 1'b0;
        overruns = 0;
        header(OP_QUAD_DATA_WRITE, 1, 1, {2'h0, 14'h0020});
        for (int k = 0; k < 10; k++) host.send_word(32'hc0de0000 + 32'(k), 4);
        host.close_frame();
        check("overrun", 32'h1, overruns);
        @(posedge clk) wr_ready <= 1'b1;
        wait_writes(9);
        for (int k = 0; k < 9; k++) expect_write(14'h0020, 32'hc0de0000 + 32'(k));
        check("write count", 32'h0, wq.size());
        $display("test fifo_full done");
    endtask
    task automatic stop_test();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        quad_wide = 1'b0;
        wr_ready = 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        test_single_write();
        test_dual_write();
        test_quad_partial();
        test_quad_wide();
        test_reads();
        test_fifo_full();
        stop_test();
    end
endmodule
